// ### shared/msd_pkg.sv
// Constants, types and helpers shared by the memory space decoder
package msd_pkg;

    // Bus widths and the direct-addressing split
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 16;
    localparam int PAGE_W  = 9;
    localparam int OFS_W   = 7;
    localparam int ALLOC_W = 8;

    // Memory-mapped registers on data page 0
    localparam logic [15:0] IMASK_ADDR = 16'h0004;
    localparam logic [15:0] GALLOC_ADDR = 16'h0005;
    localparam logic [15:0] IPEND_ADDR = 16'h0006;
    localparam logic [15:0] MMR_LO = 16'h0000;
    localparam logic [15:0] MMR_HI = 16'h005F;
    localparam logic [15:0] SCRATCH_LO = 16'h0060;
    localparam logic [15:0] SCRATCH_HI = 16'h007F;
    localparam logic [15:0] TEST_LO = 16'h002B;
    localparam logic [15:0] TEST_HI = 16'h002F;

    // Reset values
    localparam logic [15:0] IMASK_RST = 16'h0000;
    localparam logic [7:0]  GALLOC_RST = 8'h00;
    localparam logic [15:0] IPEND_RST = 16'h0000;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;

    // Global data space may only live in the upper half
    localparam int GLOBAL_TOP_BIT = 15;

    // Placement of on-chip blocks (plain defaults)
    localparam logic [15:0] DUAL0_DATA_LO = 16'h0200;
    localparam logic [15:0] DUAL0_DATA_HI = 16'h02FF;
    localparam logic [15:0] DUAL0_PROG_LO = 16'hFF00;
    localparam logic [15:0] DUAL0_PROG_HI = 16'hFFFF;
    localparam logic [15:0] DUAL1_LO = 16'h0300;
    localparam logic [15:0] DUAL1_HI = 16'h03FF;
    localparam logic [15:0] SRAM_LO = 16'h0800;
    localparam logic [15:0] SRAM_HI = 16'h0FFF;
    localparam logic [15:0] ROM_LO = 16'h0000;
    localparam logic [15:0] ROM_HI = 16'h3FFF;

    // Where an access lands
    typedef enum logic [2:0] {
        TGT_EXT,
        TGT_DUAL0,
        TGT_DUAL1,
        TGT_SCRATCH,
        TGT_SRAM,
        TGT_MMR,
        TGT_ROM,
        TGT_NONE
    } msd_tgt_e;

    // Boot phase of the program bus
    typedef enum logic {
        PH_VECTOR,
        PH_RUN
    } msd_phase_e;

    // Inclusive range check
    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

endpackage

// ### verilog/msd_pin_sync.sv
// Three-stage synchroniser with agreement filter for a device pin
`timescale 1ns/1ns
`default_nettype none
module msd_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin and filtered level
    input  wire logic pin_i,
    output logic      level_o
);

    typedef struct packed {
        logic [2:0] stg;
        logic       level;
    } msd_sync_s;

    msd_sync_s s_q;
    msd_sync_s s_d;

    // Shift in; level moves only when stages two and three agree
    always_comb begin
        s_d = s_q;
        s_d.stg = {s_q.stg[1:0], pin_i};
        if (s_q.stg[1] == s_q.stg[2]) begin
            s_d.level = s_q.stg[2];
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{stg: {3{RST_VAL}}, level: RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.level;

endmodule
`default_nettype wire

// ### verilog/msd_data_decode.sv
// Combinational data-space decode for one data address bus
`timescale 1ns/1ns
`default_nettype none
module msd_data_decode (
    // Address and configuration
    input  wire logic [15:0]   addr_i,
    input  wire logic [7:0]    galloc_i,
    input  wire logic          placement_i,
    input  wire logic          sram_en_i,
    // Result
    output msd_pkg::msd_tgt_e  tgt_o,
    output logic               global_o
);

    // Global hit: leading ones of the allocation match top address bits
    always_comb begin
        global_o = (galloc_i != msd_pkg::ZERO_BYTE)
                   && addr_i[msd_pkg::GLOBAL_TOP_BIT]
                   && ((addr_i[15:8] & galloc_i) == galloc_i);
    end

    // Priority: page 0, global, on-chip blocks, external
    always_comb begin
        if (msd_pkg::in_range(addr_i, msd_pkg::SCRATCH_LO, msd_pkg::SCRATCH_HI)) begin
            tgt_o = msd_pkg::TGT_SCRATCH;
        end else if (msd_pkg::in_range(addr_i, msd_pkg::MMR_LO, msd_pkg::MMR_HI)) begin
            tgt_o = msd_pkg::TGT_MMR;
        end else if (global_o) begin
            tgt_o = msd_pkg::TGT_EXT;
        end else if (!placement_i && msd_pkg::in_range(addr_i, msd_pkg::DUAL0_DATA_LO,
                                                       msd_pkg::DUAL0_DATA_HI)) begin
            tgt_o = msd_pkg::TGT_DUAL0;
        end else if (msd_pkg::in_range(addr_i, msd_pkg::DUAL1_LO, msd_pkg::DUAL1_HI)) begin
            tgt_o = msd_pkg::TGT_DUAL1;
        end else if (sram_en_i && msd_pkg::in_range(addr_i, msd_pkg::SRAM_LO,
                                                    msd_pkg::SRAM_HI)) begin
            tgt_o = msd_pkg::TGT_SRAM;
        end else begin
            tgt_o = msd_pkg::TGT_EXT;
        end
    end

endmodule
`default_nettype wire

// ### verilog/msd_decoder.sv
// Memory space decoder: program, data, global and I/O address steering
// Function
// - Uncovered program addresses go external
// - Placement bit one maps reconfigurable block to program
// - Placement bit resets to zero, block in data
// - Boot pin low selects on-chip boot memory
// - First fetch after reset uses address zero
// - Shared RAM enabled: both spaces share words
// - Shared RAM disabled: range goes external
// - Second and scratch blocks stay in data
// - Direct address is page pointer over offset
// - Mask, allocation, pending registers at four-six
// - Scratch RAM answers at 0060h-007Fh
// - Global space only in upper half
// - Allocation register keeps low byte only
// - Leading ones select global top bits
// - Data access drives data strobe low
// - Global hit also asserts global flag
// - Program, read and write buses independent
// - Separate I/O space decoded apart
// - Placement bit changes by set, clear, load
`timescale 1ns/1ns
`default_nettype none
module msd_decoder (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Device pins
    input  wire logic                   boot_source_select_i,
    input  wire logic                   shared_sram_enable_i,
    // Placement bit control from the status logic
    input  wire logic                   placement_set_i,
    input  wire logic                   placement_clr_i,
    input  wire logic                   placement_load_i,
    input  wire logic                   placement_load_val_i,
    // Direct addressing
    input  wire logic [8:0]             page_pointer_i,
    // Program address bus
    input  wire logic                   prog_req_i,
    input  wire logic [15:0]            prog_addr_i,
    // Data read address bus
    input  wire logic                   rd_req_i,
    input  wire logic                   rd_direct_i,
    input  wire logic [6:0]             rd_offset_i,
    input  wire logic [15:0]            rd_addr_i,
    // Data write address bus
    input  wire logic                   wr_req_i,
    input  wire logic                   wr_direct_i,
    input  wire logic [6:0]             wr_offset_i,
    input  wire logic [15:0]            wr_addr_i,
    input  wire logic [15:0]            wr_data_i,
    // I/O space
    input  wire logic                   io_req_i,
    input  wire logic [15:0]            io_addr_i,
    // Interrupt events into the pending register
    input  wire logic [15:0]            irq_event_i,
    // Program side results
    output logic [15:0]                 prog_addr_o,
    output msd_pkg::msd_tgt_e           prog_tgt_o,
    output logic                        prog_ext_o,
    // Data read results
    output logic [15:0]                 rd_addr_o,
    output msd_pkg::msd_tgt_e           rd_tgt_o,
    output logic                        rd_ext_o,
    output logic [15:0]                 mmr_rdata_o,
    // Data write results
    output logic [15:0]                 wr_addr_o,
    output msd_pkg::msd_tgt_e           wr_tgt_o,
    output logic                        wr_ext_o,
    // External data strobes
    output logic                        data_space_strobe_n_o,
    output logic                        global_access_flag_n_o,
    // I/O results
    output logic [15:0]                 io_addr_o,
    output logic                        io_strobe_n_o,
    // Register and status view
    output logic                        ram_block_placement_o,
    output logic [15:0]                 interrupt_mask_o,
    output logic [7:0]                  global_alloc_o,
    output logic [15:0]                 interrupt_pending_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Types and helpers

    typedef struct packed {
        msd_pkg::msd_phase_e phase;
        logic                placement;
        logic [15:0]         imask;
        logic [7:0]          galloc;
        logic [15:0]         ipend;
        logic [15:0]         prog_addr;
        msd_pkg::msd_tgt_e   prog_tgt;
        logic                prog_ext;
        logic [15:0]         rd_addr;
        msd_pkg::msd_tgt_e   rd_tgt;
        logic                rd_ext;
        logic [15:0]         rdata;
        logic [15:0]         wr_addr;
        msd_pkg::msd_tgt_e   wr_tgt;
        logic                wr_ext;
        logic                ds_n;
        logic                br_n;
        logic [15:0]         io_addr;
        logic                io_n;
    } msd_top_s;

    // Direct mode places the page pointer above the instruction offset
    function automatic logic [15:0] form_addr(input logic        direct,
                                              input logic [8:0]  page,
                                              input logic [6:0]  ofs,
                                              input logic [15:0] full);
        form_addr = direct ? {page, ofs} : full;
    endfunction

    msd_top_s s_q;
    msd_top_s s_d;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic boot_sel;
    logic sram_en;

    msd_pin_sync #(.RST_VAL(1'b0)) u_boot_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (boot_source_select_i),
        .level_o (boot_sel)
    );

    msd_pin_sync #(.RST_VAL(1'b0)) u_sram_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (shared_sram_enable_i),
        .level_o (sram_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data decode, one per data bus so both work in the same cycle

    logic [15:0]       rd_a;
    logic [15:0]       wr_a;
    msd_pkg::msd_tgt_e rd_t;
    msd_pkg::msd_tgt_e wr_t;
    logic              rd_g;
    logic              wr_g;

    // Formed data addresses
    assign rd_a = form_addr(rd_direct_i, page_pointer_i, rd_offset_i, rd_addr_i);
    assign wr_a = form_addr(wr_direct_i, page_pointer_i, wr_offset_i, wr_addr_i);

    msd_data_decode u_rd_dec (
        .addr_i      (rd_a),
        .galloc_i    (s_q.galloc),
        .placement_i (s_q.placement),
        .sram_en_i   (sram_en),
        .tgt_o       (rd_t),
        .global_o    (rd_g)
    );

    msd_data_decode u_wr_dec (
        .addr_i      (wr_a),
        .galloc_i    (s_q.galloc),
        .placement_i (s_q.placement),
        .sram_en_i   (sram_en),
        .tgt_o       (wr_t),
        .global_o    (wr_g)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic [15:0]       p_a;
    msd_pkg::msd_tgt_e p_t;

    // Program decode; the first fetch after reset is forced to the vector
    always_comb begin
        p_a = (s_q.phase == msd_pkg::PH_VECTOR) ? msd_pkg::RESET_VECTOR : prog_addr_i;
        if (s_q.placement && msd_pkg::in_range(p_a, msd_pkg::DUAL0_PROG_LO,
                                               msd_pkg::DUAL0_PROG_HI)) begin
            p_t = msd_pkg::TGT_DUAL0;
        end else if (msd_pkg::in_range(p_a, msd_pkg::SRAM_LO, msd_pkg::SRAM_HI)) begin
            p_t = sram_en ? msd_pkg::TGT_SRAM : msd_pkg::TGT_EXT;
        end else if (!boot_sel && msd_pkg::in_range(p_a, msd_pkg::ROM_LO,
                                                    msd_pkg::ROM_HI)) begin
            p_t = msd_pkg::TGT_ROM;
        end else begin
            p_t = msd_pkg::TGT_EXT;
        end
    end

    // Registers, strobes and pipeline of decode results
    always_comb begin
        s_d = s_q;
        // Placement bit: load beats set beats clear
        if (placement_load_i) begin
            s_d.placement = placement_load_val_i;
        end else if (placement_set_i) begin
            s_d.placement = 1'b1;
        end else if (placement_clr_i) begin
            s_d.placement = 1'b0;
        end
        // Pending flags: write one clears, a new event wins
        if (wr_req_i && wr_a == msd_pkg::IPEND_ADDR) begin
            s_d.ipend = s_q.ipend & ~wr_data_i;
        end
        s_d.ipend = s_d.ipend | irq_event_i;
        // Mask and allocation writes, no wait states
        if (wr_req_i && wr_a == msd_pkg::IMASK_ADDR) begin
            s_d.imask = wr_data_i;
        end
        if (wr_req_i && wr_a == msd_pkg::GALLOC_ADDR) begin
            s_d.galloc = wr_data_i[7:0];
        end
        // Register read data
        s_d.rdata = msd_pkg::ZERO_WORD;
        if (rd_req_i) begin
            unique case (rd_a)
                msd_pkg::IMASK_ADDR:  s_d.rdata = s_q.imask;
                msd_pkg::GALLOC_ADDR: s_d.rdata = {msd_pkg::ZERO_BYTE, s_q.galloc};
                msd_pkg::IPEND_ADDR:  s_d.rdata = s_q.ipend;
                default:              s_d.rdata = msd_pkg::ZERO_WORD;
            endcase
        end
        // Program bus result
        s_d.prog_addr = p_a;
        s_d.prog_tgt  = prog_req_i ? p_t : msd_pkg::TGT_NONE;
        s_d.prog_ext  = prog_req_i && (p_t == msd_pkg::TGT_EXT);
        if (prog_req_i) begin
            s_d.phase = msd_pkg::PH_RUN;
        end
        // Read and write buses, each on its own
        s_d.rd_addr = rd_a;
        s_d.rd_tgt  = rd_req_i ? rd_t : msd_pkg::TGT_NONE;
        s_d.rd_ext  = rd_req_i && (rd_t == msd_pkg::TGT_EXT);
        s_d.wr_addr = wr_a;
        s_d.wr_tgt  = wr_req_i ? wr_t : msd_pkg::TGT_NONE;
        s_d.wr_ext  = wr_req_i && (wr_t == msd_pkg::TGT_EXT);
        // Data strobe on every data access, global flag on a global hit
        s_d.ds_n = !(rd_req_i || wr_req_i);
        s_d.br_n = !((rd_req_i && rd_g) || (wr_req_i && wr_g));
        // I/O space has its own strobe
        s_d.io_addr = io_addr_i;
        s_d.io_n    = !io_req_i;
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{phase: msd_pkg::PH_VECTOR, placement: 1'b0,
                     imask: msd_pkg::IMASK_RST, galloc: msd_pkg::GALLOC_RST,
                     ipend: msd_pkg::IPEND_RST, prog_addr: msd_pkg::ZERO_WORD,
                     prog_tgt: msd_pkg::TGT_NONE, prog_ext: 1'b0,
                     rd_addr: msd_pkg::ZERO_WORD, rd_tgt: msd_pkg::TGT_NONE,
                     rd_ext: 1'b0, rdata: msd_pkg::ZERO_WORD,
                     wr_addr: msd_pkg::ZERO_WORD, wr_tgt: msd_pkg::TGT_NONE,
                     wr_ext: 1'b0, ds_n: 1'b1, br_n: 1'b1,
                     io_addr: msd_pkg::ZERO_WORD, io_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prog_addr_o            = s_q.prog_addr;
    assign prog_tgt_o             = s_q.prog_tgt;
    assign prog_ext_o             = s_q.prog_ext;
    assign rd_addr_o              = s_q.rd_addr;
    assign rd_tgt_o               = s_q.rd_tgt;
    assign rd_ext_o               = s_q.rd_ext;
    assign mmr_rdata_o            = s_q.rdata;
    assign wr_addr_o              = s_q.wr_addr;
    assign wr_tgt_o               = s_q.wr_tgt;
    assign wr_ext_o               = s_q.wr_ext;
    assign data_space_strobe_n_o  = s_q.ds_n;
    assign global_access_flag_n_o = s_q.br_n;
    assign io_addr_o              = s_q.io_addr;
    assign io_strobe_n_o          = s_q.io_n;
    assign ram_block_placement_o  = s_q.placement;
    assign interrupt_mask_o       = s_q.imask;
    assign global_alloc_o         = s_q.galloc;
    assign interrupt_pending_o    = s_q.ipend;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_first_fetch;
        (s_q.phase == msd_pkg::PH_VECTOR) && prog_req_i;
    endsequence

    a_ds_low: assert property (rd_req_i || wr_req_i |=> !data_space_strobe_n_o)
        else $error("data strobe not low after data access");
    a_ds_idle: assert property (!rd_req_i && !wr_req_i |=> data_space_strobe_n_o)
        else $error("data strobe low without data access");
    a_global_flag: assert property (rd_req_i && rd_g |=> !global_access_flag_n_o)
        else $error("global flag missing on global read");
    a_global_zero: assert property ((s_q.galloc == msd_pkg::ZERO_BYTE)
                                    |-> !rd_g && !wr_g)
        else $error("global hit with zero allocation");
    a_first_vector: assert property (s_first_fetch |=> prog_addr_o == msd_pkg::RESET_VECTOR)
        else $error("first fetch not at vector");
    a_prog_dual0: assert property (prog_req_i && !s_q.placement
                                   |=> prog_tgt_o != msd_pkg::TGT_DUAL0)
        else $error("dual block in program with placement clear");
    a_page_form: assert property (rd_req_i && rd_direct_i
                                  |=> rd_addr_o == {$past(page_pointer_i), $past(rd_offset_i)})
        else $error("direct address formed wrongly");
    a_galloc_write: assert property (wr_req_i && wr_a == msd_pkg::GALLOC_ADDR
                                     |=> global_alloc_o == $past(wr_data_i[7:0]))
        else $error("allocation write lost");
    a_scratch_map: assert property (rd_req_i && msd_pkg::in_range(rd_a,
                                    msd_pkg::SCRATCH_LO, msd_pkg::SCRATCH_HI)
                                    |=> rd_tgt_o == msd_pkg::TGT_SCRATCH)
        else $error("scratch address not decoded");
    a_sram_off: assert property (!sram_en && wr_req_i && !wr_g
                                 && msd_pkg::in_range(wr_a, msd_pkg::SRAM_LO, msd_pkg::SRAM_HI)
                                 |=> wr_ext_o)
        else $error("shared range not external when disabled");
    a_prog_sram_off: assert property (prog_req_i && !sram_en
                                      && msd_pkg::in_range(p_a, msd_pkg::SRAM_LO, msd_pkg::SRAM_HI)
                                      |=> prog_ext_o)
        else $error("shared range not external in program space");
    a_place_set: assert property (placement_set_i && !placement_load_i
                                  |=> ram_block_placement_o ##1 1'b1)
        else $error("placement set ignored");

endmodule
`default_nettype wire

// ### verification/msd_ext_mem.sv
// External memory model: counts the external data reads that it serves
`timescale 1ns/1ns
`default_nettype none
module msd_ext_mem (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // External data bus view
    input  wire logic        rd_ext_i,
    input  wire logic        strobe_n_i,
    // Reads served
    output logic [15:0]      rd_count_o
);
    ////////////////////////////////////////////////////////////////////////
    // A read is served only when the data strobe qualifies it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_count_o <= 16'h0000;
        end else if (rd_ext_i && !strobe_n_i) begin
            rd_count_o <= rd_count_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ### verification/msd_decoder_tb.sv
// Self-checking random bench for the memory space decoder
`timescale 1ns/1ns
`default_nettype none
module msd_decoder_tb;
    logic clk_i = 0, rst_i = 1, boot = 0, sen = 1, ps = 0, pc = 0, pld = 0, plv = 0;
    logic pr = 0, rr = 0, rd = 0, wr = 0, io = 0, pl = 0, first = 1, wd_n = 0;
    logic [15:0] pa = 16'h0000, ra = 16'h0000, wa = 16'h0000, wd = 16'h0000;
    logic [15:0] ia = 16'h0000, irq = 16'h0000, rb, poa, roa, woa, mrd, ioa, imk, ipd, xc;
    logic [8:0]  pp = 9'h000;
    logic [6:0]  ofs = 7'h00;
    logic [7:0]  ga = 8'h00, gao;
    logic        pe, re, we, dsn, gfn, iosn, plo;
    msd_pkg::msd_tgt_e pt, rt, wt;
    int          err_count = 0, compares = 0, seed = 5, exp_rd = 0, i, k;
    logic [7:0]  allocs [8] = '{8'h00, 8'h80, 8'hC0, 8'hE0, 8'hF0, 8'hF8, 8'hFC, 8'hFF};
    logic [15:0] corn [16] = '{16'h0060, 16'h007F, 16'h005F, 16'h0005, 16'h0200, 16'h02FF,
        16'h0300, 16'h03FF, 16'h0800, 16'h0FFF, 16'h3FFF, 16'h4000, 16'hFF00, 16'hFFFF,
        16'h8000, 16'hE000};

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and far-side model
    always #25 clk_i = ~clk_i;
    msd_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .boot_source_select_i(boot),
        .shared_sram_enable_i(sen), .placement_set_i(ps), .placement_clr_i(pc),
        .placement_load_i(pld), .placement_load_val_i(plv), .page_pointer_i(pp),
        .prog_req_i(pr), .prog_addr_i(pa), .rd_req_i(rr), .rd_direct_i(rd),
        .rd_offset_i(ofs), .rd_addr_i(ra), .wr_req_i(wr), .wr_direct_i(wd_n),
        .wr_offset_i(ofs), .wr_addr_i(wa), .wr_data_i(wd), .io_req_i(io),
        .io_addr_i(ia), .irq_event_i(irq), .prog_addr_o(poa), .prog_tgt_o(pt),
        .prog_ext_o(pe), .rd_addr_o(roa), .rd_tgt_o(rt), .rd_ext_o(re),
        .mmr_rdata_o(mrd), .wr_addr_o(woa), .wr_tgt_o(wt), .wr_ext_o(we),
        .data_space_strobe_n_o(dsn), .global_access_flag_n_o(gfn), .io_addr_o(ioa),
        .io_strobe_n_o(iosn), .ram_block_placement_o(plo), .interrupt_mask_o(imk),
        .global_alloc_o(gao), .interrupt_pending_o(ipd));
    msd_ext_mem EXT (.clk_i(clk_i), .rst_i(rst_i), .rd_ext_i(re), .strobe_n_i(dsn),
        .rd_count_o(xc));

    ////////////////////////////////////////////////////////////////////////
    // Expected decode worked out from the address map
    function automatic logic glob(input logic [15:0] a);
        return a[15] && ga != 8'h00 && ((a[15:8] & ga) == ga);
    endfunction
    function automatic msd_pkg::msd_tgt_e dtgt(input logic [15:0] a);
        if (a >= 16'h0060 && a <= 16'h007F) return msd_pkg::TGT_SCRATCH;
        if (a <= 16'h005F) return msd_pkg::TGT_MMR;
        if (glob(a)) return msd_pkg::TGT_EXT;
        if (!pl && a[15:8] == 8'h02) return msd_pkg::TGT_DUAL0;
        if (a[15:8] == 8'h03) return msd_pkg::TGT_DUAL1;
        if (sen && a >= 16'h0800 && a <= 16'h0FFF) return msd_pkg::TGT_SRAM;
        return msd_pkg::TGT_EXT;
    endfunction
    function automatic msd_pkg::msd_tgt_e ptgt(input logic [15:0] a);
        if (pl && a >= 16'hFF00) return msd_pkg::TGT_DUAL0;
        if (a >= 16'h0800 && a <= 16'h0FFF)
            return sen ? msd_pkg::TGT_SRAM : msd_pkg::TGT_EXT;
        if (!boot && a <= 16'h3FFF) return msd_pkg::TGT_ROM;
        return msd_pkg::TGT_EXT;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Compare, step, closing and bus tasks
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step;
        @(posedge clk_i);
        #5;
    endtask
    task summarize;
        $display("Mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One cycle on all four buses at once, outputs checked one cycle on
    task go(input logic p, input logic r, input logic d, input logic w, input logic o);
        logic [15:0] ea, ep, ew;
        ea = d ? {pp, ofs} : ra;
        ew = wd_n ? {pp, ofs} : wa;
        ep = first ? 16'h0000 : pa;
        pr = p;
        rr = r;
        rd = d;
        wr = w;
        io = o;
        step;
        if (p) begin
            chk(poa, ep);
            chk(16'(pt), 16'(ptgt(ep)));
            chk(16'(pe), 16'(ptgt(ep) == msd_pkg::TGT_EXT));
            first = 0;
        end
        if (r) begin
            chk(roa, ea);
            chk(16'(rt), 16'(dtgt(ea)));
            chk(16'(re), 16'(dtgt(ea) == msd_pkg::TGT_EXT));
            if (dtgt(ea) == msd_pkg::TGT_EXT) exp_rd++;
        end
        if (w) chk(16'(wt), 16'(dtgt(ew)));
        if (w) chk(woa, ew);
        chk(16'(dsn), 16'(!(r || w)));
        chk(16'(gfn), 16'(!((r && glob(ea)) || (w && glob(ew)))));
        if (o) chk(ioa, ia);
        chk(16'(iosn), 16'(!o));
    endtask
    task idle;
        pr = 0;
        rr = 0;
        wr = 0;
        io = 0;
        step;
    endtask
    task wreg(input logic [15:0] a, input logic [15:0] v);
        wd_n = 0;
        wa = a;
        wd = v;
        go(0, 0, 0, 1, 0);
        if (a == 16'h0005) ga = v[7:0];
        idle;
    endtask
    task plc(input logic s, input logic c, input logic l, input logic v);
        ps = s;
        pc = c;
        pld = l;
        plv = v;
        pl = l ? v : (s ? 1'b1 : (c ? 1'b0 : pl));
        step;
        ps = 0;
        pc = 0;
        pld = 0;
        step;
        step;
        chk(16'(plo), 16'(pl));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        #2000000;
        err_count++;
        summarize;
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        #5;
        chk(16'(pt), 16'(msd_pkg::TGT_NONE));
        chk({15'h0000, plo}, 16'h0000);
        chk({gao, dsn, gfn, 6'h00}, 16'h00C0);
        chk(imk | ipd, 16'h0000);
        rst_i = 0;
        repeat (5) step;
        pa = 16'h1234;
        go(1, 0, 0, 0, 0);
        go(1, 0, 0, 0, 0);
        idle;
        wreg(16'h0005, 16'h12E0);
        chk({8'h00, gao}, 16'h00E0);
        ra = 16'h0005;
        go(0, 1, 0, 0, 0);
        chk(mrd, 16'h00E0);
        idle;
        wreg(16'h0004, 16'hA5A5);
        chk(imk, 16'hA5A5);
        ra = 16'h0004;
        go(0, 1, 0, 0, 0);
        chk(mrd, 16'hA5A5);
        idle;
        irq = 16'h0008;
        step;
        irq = 16'h0000;
        step;
        chk(ipd, 16'h0008);
        wreg(16'h0006, 16'h0008);
        chk(ipd, 16'h0000);
        // Event held over the clear cycle and the idle cycle after it: the flag stays set
        irq = 16'h0010;
        wreg(16'h0006, 16'h0010);
        irq = 16'h0000;
        step;
        chk(ipd, 16'h0010);
        for (k = 0; k < 8; k++) begin
            boot = k[0];
            sen = k[1];
            repeat (5) step;
            plc(k[2], 1'b1, k[0], k[2]);
            rb = 16'($random(seed));
            wreg(16'h0005, {rb[15:8], allocs[k]});
            for (i = 0; i < 24; i++) begin
                rb = 16'($random(seed));
                pa = (i % 3 == 0) ? corn[(i / 3 + k) % 16] : 16'($random(seed));
                ra = (i % 3 == 1) ? corn[(i + k) % 16] : 16'($random(seed));
                wa = 16'($random(seed)) | 16'h0080;
                wd = 16'($random(seed));
                ia = 16'($random(seed));
                pp = 9'($random(seed));
                ofs = 7'($random(seed));
                wd_n = (i % 7 == 3) && pp != 9'h000;
                go(rb[0], rb[1] | rb[2], i % 5 == 0, rb[3], rb[4]);
            end
            idle;
        end
        chk(xc, 16'(exp_rd));
        summarize;
    end
endmodule
`default_nettype wire
